// *** src/etpu_top.sv ***
`timescale 1ns/1ps
`include "etpu_cfg.svh"

// Contract
// - stamp event edges at 100 ns resolution
// - no event stamping before time valid
// - setting picks rising or falling event edge
// - capture time per edge, keep watching
// - queue holds up to 23 stamps
// - host drains stamps oldest first, promptly
// - pulse times set at 100 ns resolution
// - no output pulses before time valid
// - one-shot gives exactly one timed pulse
// - repeat: first pulse, then every interval ms
// - pulse width and polarity selectable
// - one-shot may hold a fixed level instead
// - signed bias up to 99999 ns, on event stamps and pulse times, not on time reads
// - negative bias later, positive bias earlier
// - time valid drops while bias settles
// - time valid from receiver enables functions
module etpu_top #(
  parameter int unsigned DEPTH         = `ETPU_EVT_DEPTH,
  parameter int unsigned SETTLE_CYCLES =
    int'((64'(`ETPU_SETTLE_MS) * 64'(`ETPU_NS_PER_MS)) / `ETPU_CLK_NS)
) (
  // clock and reset
  input  wire logic        clk,
  input  wire logic        reset_n,
  // avalon-mm slave
  input  wire logic [5:0]  avs_address,
  input  wire logic        avs_read,
  input  wire logic        avs_write,
  input  wire logic [31:0] avs_writedata,
  input  wire logic [3:0]  avs_byteenable,
  output logic [31:0]      avs_readdata,
  output logic             avs_waitrequest,
  // receiver time status
  input  wire logic        time_valid,
  // event input and timed pulse output
  input  wire logic        event_in,
  output logic             pulse_out
);

  // ----------------------------------------------------------------------
  // derived counts
  // ----------------------------------------------------------------------
  localparam int unsigned TICK_CYCLES = `ETPU_RES_NS / `ETPU_CLK_NS;
  localparam logic        TICK_LAST   = 1'(TICK_CYCLES - 1);
  localparam int unsigned TICKS_PER_MS = `ETPU_NS_PER_MS / `ETPU_RES_NS;
  localparam int unsigned LW = $clog2(DEPTH+1);

  // byte-lane merge for partial writes
  function automatic logic [31:0] merge(input logic [31:0] old,
                                        input logic [31:0] wd,
                                        input logic [3:0]  be);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (be[i]) begin
        r[8*i +: 8] = wd[8*i +: 8];
      end
    end
    return r;
  endfunction

  // clamp a signed word into the bias range
  function automatic logic signed [`ETPU_BIAS_W-1:0] clamp_bias(
    input logic signed [31:0] v);
    logic signed [31:0] r;
    r = v;
    if (v > `ETPU_BIAS_MAX_NS) begin
      r = `ETPU_BIAS_MAX_NS;
    end else if (v < -`ETPU_BIAS_MAX_NS) begin
      r = -`ETPU_BIAS_MAX_NS;
    end
    return r[`ETPU_BIAS_W-1:0];
  endfunction

  // ----------------------------------------------------------------------
  // state and wires
  // ----------------------------------------------------------------------
  etpu_pkg::etpu_state_s s;
  etpu_pkg::etpu_state_s next_s;

  logic                                 ev_sync;
  logic                                 req;
  logic                                 accept;
  logic                                 tick;
  logic                                 time_ok;
  logic                                 ev_edge;
  logic                                 ev_push;
  logic                                 q_ready;
  logic                                 q_valid;
  logic                                 q_pop;
  logic [`ETPU_TIME_W-1:0]              q_data;
  logic [LW-1:0]                        q_level;
  logic signed [`ETPU_BIAS_W-1:0]       bias_ticks;
  logic [`ETPU_TIME_W-1:0]              biased;
  logic [`ETPU_TIME_W-1:0]              intv_ticks;
  logic [31:0]                          wmerged;
  logic                                 pol;

  // ----------------------------------------------------------------------
  // event input path
  // ----------------------------------------------------------------------
  // pulses shorter than one clock can slip between samples
  etpu_sync u_sync (
    .clk     (clk),
    .reset_n (reset_n),
    .din     (event_in),
    .dout    (ev_sync)
  );

  // queue absorbs bursts; host reads drain it
  etpu_fifo #(
    .WIDTH (`ETPU_TIME_W),
    .DEPTH (DEPTH)
  ) u_fifo (
    .clk       (clk),
    .reset_n   (reset_n),
    .in_valid  (ev_push),
    .in_ready  (q_ready),
    .in_data   (biased),
    .out_valid (q_valid),
    .out_ready (q_pop),
    .out_data  (q_data),
    .level     (q_level)
  );

  // ----------------------------------------------------------------------
  // time base and bias
  // ----------------------------------------------------------------------
  // one time unit every TICK_CYCLES clocks
  assign tick = (s.prescale == TICK_LAST);
  // receiver status gated while the loops settle after a bias change
  assign time_ok = time_valid & (s.settle == '0);
  // bias kept in ns, applied in whole time units
  assign bias_ticks = s.bias / $signed(`ETPU_BIAS_W'(`ETPU_RES_NS));
  // positive bias makes local time run ahead, so events fire earlier
  assign biased = s.now +
    {{(`ETPU_TIME_W-`ETPU_BIAS_W){bias_ticks[`ETPU_BIAS_W-1]}},
     bias_ticks};
  assign intv_ticks = `ETPU_TIME_W'(s.pop_intv) *
                      `ETPU_TIME_W'(TICKS_PER_MS);

  // ----------------------------------------------------------------------
  // event edge detection
  // ----------------------------------------------------------------------
  // falling or rising edge per control bit
  assign ev_edge = s.ctrl[`ETPU_B_EVT_FALL] ?
                   (s.ev_prev & ~ev_sync) :
                   (~s.ev_prev & ev_sync);
  // stamp taken from the detecting cycle, only with valid time
  assign ev_push = ev_edge & time_ok &
                   s.ctrl[`ETPU_B_EVT_EN];

  // ----------------------------------------------------------------------
  // bus handshake
  // ----------------------------------------------------------------------
  // one wait state: first cycle latches read data, second completes
  assign req             = avs_read | avs_write;
  assign accept          = req & s.ack;
  assign avs_waitrequest = req & ~s.ack;
  assign avs_readdata    = s.rdata;
  // reading the high word of the head pops it
  assign q_pop = accept & avs_read &
                 (avs_address == `ETPU_A_EVT_HI);
  assign pol = s.pop_ctrl[`ETPU_B_POP_POL];

  // ----------------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------------
  always_comb begin
    next_s   = s;
    wmerged  = '0;

    // time base runs free, loaded by software writes below
    next_s.prescale = tick ? 1'b0 : s.prescale + 1'b1;
    if (tick) begin
      next_s.now = s.now + 1'b1;
    end
    if (s.settle != '0) begin
      next_s.settle = s.settle - 1'b1;
    end
    next_s.ev_prev = ev_sync;

    // pulse sequencer
    case (s.pop_st)
      etpu_pkg::POP_IDLE: begin
        next_s.pop_out = ~pol;
      end
      etpu_pkg::POP_WAIT: begin
        next_s.pop_out = ~pol;
        if (time_ok && biased >= s.pop_target) begin
          if (s.pop_ctrl[`ETPU_B_POP_HOLD] &&
              !s.pop_ctrl[`ETPU_B_POP_REPEAT]) begin
            next_s.pop_st  = etpu_pkg::POP_HOLD;
            next_s.pop_out = s.pop_ctrl[`ETPU_B_POP_LEVEL];
          end else begin
            next_s.pop_st  = etpu_pkg::POP_ACTIVE;
            next_s.pop_out = pol;
            next_s.pop_cnt = s.pop_width;
            if (s.pop_ctrl[`ETPU_B_POP_REPEAT]) begin
              next_s.pop_target = s.pop_target + intv_ticks;
            end
          end
        end
      end
      etpu_pkg::POP_ACTIVE: begin
        next_s.pop_out = pol;
        if (tick) begin
          next_s.pop_cnt = s.pop_cnt - 1'b1;
          // zero width still yields one time unit
          if (s.pop_cnt <= 32'h0000_0001) begin
            next_s.pop_out = ~pol;
            if (s.pop_ctrl[`ETPU_B_POP_REPEAT]) begin
              next_s.pop_st = etpu_pkg::POP_WAIT;
            end else begin
              next_s.pop_st = etpu_pkg::POP_IDLE;
              next_s.pop_ctrl[`ETPU_B_POP_ARM] = 1'b0;
            end
          end
        end
      end
      etpu_pkg::POP_HOLD: begin
        next_s.pop_out = s.pop_ctrl[`ETPU_B_POP_LEVEL];
      end
      default: begin
        next_s.pop_st = etpu_pkg::POP_IDLE;
      end
    endcase

    // overflow: a dropped event wins over a clear in the same cycle
    if (avs_write && accept && avs_address == `ETPU_A_STATUS &&
        avs_byteenable[0] && avs_writedata[`ETPU_B_ST_OVF]) begin
      next_s.overflow = 1'b0;
    end
    if (ev_push && !q_ready) begin
      next_s.overflow = 1'b1;
    end

    // bus phase one: latch read data
    if (req && !s.ack) begin
      next_s.ack   = 1'b1;
      next_s.rdata = '0;
      case (avs_address)
        `ETPU_A_CTRL:      next_s.rdata = 32'(s.ctrl);
        `ETPU_A_STATUS: begin
          next_s.rdata[`ETPU_B_ST_TIME_OK] = time_ok;
          next_s.rdata[`ETPU_B_ST_PENDING] = q_valid;
          next_s.rdata[`ETPU_B_ST_OVF]     = s.overflow;
          next_s.rdata[`ETPU_B_ST_LVL_LO +: LW] = q_level;
          next_s.rdata[`ETPU_B_ST_POP_LO +: 2]  = s.pop_st;
        end
        `ETPU_A_BIAS:      next_s.rdata = 32'(s.bias);
        `ETPU_A_TIME_LO:   next_s.rdata = s.now[31:0];
        `ETPU_A_TIME_HI:   next_s.rdata = s.now[63:32];
        `ETPU_A_EVT_LO:    next_s.rdata = q_data[31:0];
        `ETPU_A_EVT_HI:    next_s.rdata = q_data[63:32];
        `ETPU_A_POP_CTRL:  next_s.rdata = 32'(s.pop_ctrl);
        `ETPU_A_POP_T_LO:  next_s.rdata = s.pop_target[31:0];
        `ETPU_A_POP_T_HI:  next_s.rdata = s.pop_target[63:32];
        `ETPU_A_POP_INTV:  next_s.rdata = 32'(s.pop_intv);
        `ETPU_A_POP_WIDTH: next_s.rdata = s.pop_width;
        default:           next_s.rdata = '0;
      endcase
    end

    // bus phase two: complete, writes take effect here
    if (accept) begin
      next_s.ack = 1'b0;
      if (avs_write) begin
        case (avs_address)
          `ETPU_A_CTRL: begin
            wmerged     = merge(32'(s.ctrl), avs_writedata, avs_byteenable);
            next_s.ctrl = wmerged[1:0];
          end
          `ETPU_A_BIAS: begin
            wmerged       = merge(32'(s.bias), avs_writedata,
                                  avs_byteenable);
            next_s.bias   = clamp_bias(wmerged);
            next_s.settle = SETTLE_CYCLES;
          end
          `ETPU_A_TIME_LO: begin
            next_s.time_stage = merge(s.time_stage, avs_writedata,
                                      avs_byteenable);
          end
          `ETPU_A_TIME_HI: begin
            // both halves land together to avoid a torn time
            wmerged         = merge(s.now[63:32], avs_writedata,
                                    avs_byteenable);
            next_s.now      = {wmerged, s.time_stage};
            next_s.prescale = 1'b0;
          end
          `ETPU_A_POP_CTRL: begin
            wmerged = merge(32'(s.pop_ctrl), avs_writedata,
                            avs_byteenable);
            next_s.pop_ctrl = wmerged[`ETPU_POP_CTRL_W-1:0];
            // any write re-arms or stops the sequencer
            if (wmerged[`ETPU_B_POP_ARM]) begin
              next_s.pop_st = etpu_pkg::POP_WAIT;
            end else begin
              next_s.pop_st = etpu_pkg::POP_IDLE;
            end
            next_s.pop_out = ~wmerged[`ETPU_B_POP_POL];
          end
          `ETPU_A_POP_T_LO: begin
            next_s.pop_target[31:0] = merge(s.pop_target[31:0],
                                            avs_writedata, avs_byteenable);
          end
          `ETPU_A_POP_T_HI: begin
            next_s.pop_target[63:32] = merge(s.pop_target[63:32],
                                             avs_writedata, avs_byteenable);
          end
          `ETPU_A_POP_INTV: begin
            wmerged = merge(32'(s.pop_intv), avs_writedata,
                            avs_byteenable);
            next_s.pop_intv = wmerged[`ETPU_INTV_W-1:0];
          end
          `ETPU_A_POP_WIDTH: begin
            next_s.pop_width = merge(s.pop_width, avs_writedata,
                                     avs_byteenable);
          end
          default: begin
            next_s.ack = 1'b0;
          end
        endcase
      end
    end
  end

  // ----------------------------------------------------------------------
  // state register
  // ----------------------------------------------------------------------
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      s          <= '0;
      s.ctrl     <= `ETPU_CTRL_RST;
      s.pop_ctrl <= `ETPU_POP_CTRL_RST;
    end else begin
      s <= next_s;
    end
  end

  assign pulse_out = s.pop_out;

endmodule // etpu_top

// *** src/etpu_cfg.svh ***
`ifndef ETPU_CFG_SVH
`define ETPU_CFG_SVH

// ----------------------------------------------------------------------
// timing figures
// ----------------------------------------------------------------------
`define ETPU_CLK_NS        50
`define ETPU_RES_NS        100
`define ETPU_NS_PER_MS     1000000
`define ETPU_SETTLE_MS     3000
`define ETPU_BIAS_MAX_NS   99999
`define ETPU_EVT_DEPTH     23
`define ETPU_TIME_W        64
`define ETPU_BIAS_W        18
`define ETPU_INTV_W        27

// ----------------------------------------------------------------------
// register byte offsets
// ----------------------------------------------------------------------
`define ETPU_A_CTRL        6'h00
`define ETPU_A_STATUS      6'h04
`define ETPU_A_BIAS        6'h08
`define ETPU_A_TIME_LO     6'h0C
`define ETPU_A_TIME_HI     6'h10
`define ETPU_A_EVT_LO      6'h14
`define ETPU_A_EVT_HI      6'h18
`define ETPU_A_POP_CTRL    6'h1C
`define ETPU_A_POP_T_LO    6'h20
`define ETPU_A_POP_T_HI    6'h24
`define ETPU_A_POP_INTV    6'h28
`define ETPU_A_POP_WIDTH   6'h2C

// ----------------------------------------------------------------------
// field positions and reset values
// ----------------------------------------------------------------------
`define ETPU_B_EVT_EN      0
`define ETPU_B_EVT_FALL    1
`define ETPU_B_ST_TIME_OK  0
`define ETPU_B_ST_PENDING  1
`define ETPU_B_ST_OVF      2
`define ETPU_B_ST_LVL_LO   8
`define ETPU_B_ST_POP_LO   16
`define ETPU_B_POP_ARM     0
`define ETPU_B_POP_REPEAT  1
`define ETPU_B_POP_POL     2
`define ETPU_B_POP_HOLD    3
`define ETPU_B_POP_LEVEL   4
`define ETPU_POP_CTRL_W    5
`define ETPU_POP_CTRL_RST  5'h04
`define ETPU_CTRL_RST      2'h0

`endif

// *** src/etpu_pkg.sv ***
`include "etpu_cfg.svh"

package etpu_pkg;

  // pulse generator sequence
  typedef enum logic [1:0] {
    POP_IDLE,
    POP_WAIT,
    POP_ACTIVE,
    POP_HOLD
  } etpu_pop_e;

  typedef logic [`ETPU_TIME_W-1:0] etpu_time_t;

  // whole state of the top level, registered as one word
  typedef struct packed {
    logic                           ack;
    logic [31:0]                    rdata;
    logic [1:0]                     ctrl;
    logic                           ev_prev;
    logic                           overflow;
    logic signed [`ETPU_BIAS_W-1:0] bias;
    logic [31:0]                    settle;
    logic                           prescale;
    etpu_time_t                     now;
    logic [31:0]                    time_stage;
    logic [`ETPU_POP_CTRL_W-1:0]    pop_ctrl;
    etpu_time_t                     pop_target;
    logic [`ETPU_INTV_W-1:0]        pop_intv;
    logic [31:0]                    pop_width;
    logic [31:0]                    pop_cnt;
    etpu_pop_e                      pop_st;
    logic                           pop_out;
  } etpu_state_s;

endpackage

// *** src/etpu_sync.sv ***
`timescale 1ns/1ps

// ----------------------------------------------------------------------
// two-stage level synchroniser
// ----------------------------------------------------------------------
module etpu_sync (
  // clock and reset
  input  wire logic clk,
  input  wire logic reset_n,
  // level in and out
  input  wire logic din,
  output logic      dout
);

  typedef struct packed {
    logic meta;
    logic sync;
  } etpu_sync_s;

  etpu_sync_s s;
  etpu_sync_s next_s;

  // first stage feeds only the second
  always_comb begin
    next_s      = s;
    next_s.meta = din;
    next_s.sync = s.meta;
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  assign dout = s.sync;

endmodule // etpu_sync

// *** src/etpu_fifo.sv ***
`timescale 1ns/1ps

// ----------------------------------------------------------------------
// flip-flop queue, oldest word at the head
// ----------------------------------------------------------------------
module etpu_fifo #(
  parameter int unsigned WIDTH = 64,
  parameter int unsigned DEPTH = 23
) (
  // clock and reset
  input  wire logic                           clk,
  input  wire logic                           reset_n,
  // fill side
  input  wire logic                           in_valid,
  output logic                                in_ready,
  input  wire logic [WIDTH-1:0]               in_data,
  // drain side
  output logic                                out_valid,
  input  wire logic                           out_ready,
  output logic [WIDTH-1:0]                    out_data,
  // fill level
  output logic [$clog2(DEPTH+1)-1:0]          level
);

  localparam int unsigned PW = $clog2(DEPTH);
  localparam int unsigned CW = $clog2(DEPTH+1);
  localparam logic [PW-1:0] LAST = PW'(DEPTH - 1);
  localparam logic [CW-1:0] FULL = CW'(DEPTH);

  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [PW-1:0]               wr;
    logic [PW-1:0]               rd;
    logic [CW-1:0]               cnt;
  } etpu_fifo_s;

  etpu_fifo_s s;
  etpu_fifo_s next_s;
  logic       push;
  logic       pop;

  assign in_ready  = (s.cnt != FULL);
  assign out_valid = (s.cnt != '0);
  assign out_data  = s.mem[s.rd];
  assign level     = s.cnt;
  assign push      = in_valid & in_ready;
  assign pop       = out_ready & out_valid;

  // pointers wrap by compare since depth need not be a power of two
  always_comb begin
    next_s = s;
    if (push) begin
      next_s.mem[s.wr] = in_data;
      next_s.wr        = (s.wr == LAST) ? '0 : s.wr + 1'b1;
    end
    if (pop) begin
      next_s.rd = (s.rd == LAST) ? '0 : s.rd + 1'b1;
    end
    if (push && !pop) begin
      next_s.cnt = s.cnt + 1'b1;
    end else if (pop && !push) begin
      next_s.cnt = s.cnt - 1'b1;
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

endmodule // etpu_fifo

// *** test/etpu_checker.sv ***
`timescale 1ns/1ps
// ------------------------------------------
// bus handshake and pulse timing checks
// ------------------------------------------
module etpu_checker #(
  parameter int unsigned DEPTH         = 23,
  parameter int unsigned SETTLE_CYCLES = 20
) (
  // clock and reset
  input wire logic        clk,
  input wire logic        reset_n,
  // bus
  input wire logic [5:0]  avs_address,
  input wire logic        avs_read,
  input wire logic        avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0]  avs_byteenable,
  input wire logic [31:0] avs_readdata,
  input wire logic        avs_waitrequest,
  // pins
  input wire logic        time_valid,
  input wire logic        event_in,
  input wire logic        pulse_out
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);
  logic        req;
  logic        wr_ok;
  logic        act;
  logic        pol;
  logic [31:0] wid;
  logic [31:0] run;
  logic [31:0] stl;
  assign req   = avs_read | avs_write;
  assign wr_ok = avs_write & ~avs_waitrequest;
  assign act   = pulse_out == pol;
  // shadow of width, polarity and settle hold, taken from bus writes
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      pol <= 1'b1;
      wid <= 32'h0;
      run <= 32'h0;
      stl <= 32'h0;
    end else begin
      run <= act ? run + 32'h1 : 32'h0;
      stl <= (stl != 32'h0) ? stl - 32'h1 : 32'h0;
      if (wr_ok && avs_address == 6'h1C) pol <= avs_writedata[2];
      if (wr_ok && avs_address == 6'h2C) wid <= avs_writedata;
      if (wr_ok && avs_address == 6'h08) stl <= SETTLE_CYCLES;
    end
  end
  sequence s_req_new;
    req && !$past(req);
  endsequence
  // pulse edges not caused by a register write
  sequence s_self_rise;
    $rose(act) && !$past(wr_ok);
  endsequence
  sequence s_self_fall;
    $fell(act) && !$past(wr_ok);
  endsequence
  property p_wait_first; s_req_new |-> avs_waitrequest; endproperty
  property p_wait_one; req && avs_waitrequest |=> !avs_waitrequest; endproperty
  property p_wait_idle; !req |-> !avs_waitrequest; endproperty
  property p_rd_stand; !req |=> $stable(avs_readdata); endproperty
  property p_pulse_width;
    s_self_fall |-> run + 32'h1 >= 2 * wid && run <= 2 * wid;
  endproperty
  property p_pulse_valid; s_self_rise |-> $past(time_valid); endproperty
  property p_pulse_settle; s_self_rise |-> stl < 32'h2; endproperty
  property p_pulse_gap; s_self_fall |-> (!act)[*8]; endproperty
  a_wait_first: assert property (p_wait_first)
    else $error("new request not held off");
  a_wait_one: assert property (p_wait_one)
    else $error("request held off more than one cycle");
  a_wait_idle: assert property (p_wait_idle)
    else $error("wait raised with no request");
  a_rd_stand: assert property (p_rd_stand)
    else $error("read data moved while idle");
  a_pulse_width: assert property (p_pulse_width)
    else $error("pulse length differs from width");
  a_pulse_valid: assert property (p_pulse_valid)
    else $error("pulse without valid time");
  a_pulse_settle: assert property (p_pulse_settle)
    else $error("pulse during bias settle");
  a_pulse_gap: assert property (p_pulse_gap)
    else $error("pulse restarted at once");
endmodule // etpu_checker

bind etpu_top etpu_checker #(
  .DEPTH(DEPTH),
  .SETTLE_CYCLES(SETTLE_CYCLES)
) chk_u (.clk, .reset_n, .avs_address, .avs_read, .avs_write,
  .avs_writedata, .avs_byteenable, .avs_readdata, .avs_waitrequest,
  .time_valid, .event_in, .pulse_out);

// *** test/etpu_partner.sv ***
`timescale 1ns/1ps
// ------------------------------------------
// event source and pulse counter
// ------------------------------------------
module etpu_partner #(
  parameter int GAP = 80000
) (
  // clock
  input wire logic clk,
  // event line and pulse sense
  output logic     event_in,
  input wire logic pulse_out
);
  int   pulses = 0;
  logic last;
  initial event_in = 1'b0;
  // count rising edges seen on the pulse line
  always @(posedge clk) begin
    last <= pulse_out;
    if (pulse_out && !last) pulses <= pulses + 1;
  end
  // park the line at an idle level
  task automatic level(input logic v);
    @(posedge clk);
    event_in <= v;
  endtask
  // n events, 3 cycles wide, GAP+4 cycles from one start to the next
  task automatic send(input int n, input logic idle);
    for (int i = 0; i < n; i++) begin
      @(posedge clk);
      event_in <= ~idle;
      repeat (3) @(posedge clk);
      event_in <= idle;
      repeat (GAP) @(posedge clk);
    end
  endtask
endmodule // etpu_partner

// *** test/test_etpu_top.sv ***
`timescale 1ns/1ps
// ------------------------------------------
// bench
// ------------------------------------------
module test_etpu_top;
  localparam int DEP = 4;
  logic        clk = 1'b0;
  logic        reset_n = 1'b0;
  logic [5:0]  avs_address = 6'h00;
  logic        avs_read = 1'b0;
  logic        avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0;
  logic [3:0]  avs_byteenable = 4'hF;
  logic [31:0] avs_readdata;
  logic        avs_waitrequest;
  logic        time_valid = 1'b0;
  logic        event_in;
  logic        pulse_out;
  int          failures = 0;
  int          samples_checked = 0;
  int          cycles = 0;
  logic [31:0] d;
  logic [31:0] e;
  always #25 clk = ~clk;
  etpu_top #(.DEPTH(DEP), .SETTLE_CYCLES(20)) dut_u (.clk, .reset_n,
    .avs_address, .avs_read, .avs_write, .avs_writedata, .avs_byteenable,
    .avs_readdata, .avs_waitrequest, .time_valid, .event_in, .pulse_out);
  etpu_partner #(.GAP(40)) part_u (.clk, .event_in, .pulse_out);
  task automatic end_of_test;
    $display("checks %0d failures %0d", samples_checked, failures);
    if (failures == 0 && samples_checked > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  // hang guard, well above the longest run
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 80000) begin
      failures++;
      end_of_test();
    end
  end
  task automatic chk(input logic [31:0] s, input logic [31:0] x);
    samples_checked++;
    if (s !== x) begin
      failures++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, s, x);
    end
  endtask
  // one bus cycle; no fixed latency assumed
  task automatic bus(input logic w, input logic [5:0] a,
                     input logic [31:0] v);
    @(posedge clk);
    avs_address <= a;
    avs_writedata <= v;
    avs_read <= !w;
    avs_write <= w;
    do @(posedge clk); while (avs_waitrequest !== 1'b0);
    d = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
  endtask
  task automatic wr(input logic [5:0] a, input logic [31:0] v);
    bus(1'b1, a, v);
  endtask
  task automatic rd(input logic [5:0] a);
    bus(1'b0, a, 32'h0);
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
  endtask
  task automatic t_reset;
    rd(6'h00);
    chk(d, 32'h0);
    rd(6'h1C);
    chk(d, 32'h4);
    rd(6'h04);
    chk(d, 32'h0);
    rd(6'h3C);
    chk(d, 32'h0);
    $display("reset values done");
  endtask
  task automatic t_events;
    wr(6'h00, 32'h1);
    part_u.send(1, 1'b0);
    rd(6'h04);
    chk(d, 32'h0);
    time_valid <= 1'b1;
    wr(6'h0C, 32'h100);
    wr(6'h10, 32'h0);
    part_u.send(DEP + 1, 1'b0);
    rd(6'h04);
    chk(d, 32'h7 | (DEP << 8));
    for (int i = 0; i < DEP; i++) begin
      rd(6'h14);
      if (i > 0) chk(d - e, 32'd22);
      e = d;
      rd(6'h18);
      chk(d, 32'h0);
    end
    rd(6'h04);
    chk(d, 32'h5);
    wr(6'h04, 32'h4);
    rd(6'h04);
    chk(d, 32'h1);
    // disable before parking high, or the move itself is an event
    wr(6'h00, 32'h2);
    part_u.level(1'b1);
    wr(6'h00, 32'h3);
    part_u.send(1, 1'b1);
    rd(6'h04);
    chk(d, 32'h103);
    rd(6'h18);
    wr(6'h00, 32'h0);
    $display("event stamps done");
  endtask
  task automatic t_pulse;
    wr(6'h2C, 32'h4);
    time_valid <= 1'b0;
    wr(6'h20, 32'h0);
    wr(6'h24, 32'h0);
    wr(6'h1C, 32'h5);
    tick(50);
    chk(32'(part_u.pulses), 32'h0);
    rd(6'h04);
    chk(d & 32'h30001, 32'h10000);
    wr(6'h08, 32'd1000);
    time_valid <= 1'b1;
    tick(10);
    chk(32'(part_u.pulses), 32'h0);
    tick(60);
    chk(32'(part_u.pulses), 32'h1);
    rd(6'h1C);
    chk(d, 32'h4);
    wr(6'h1C, 32'h0);
    tick(2);
    chk({31'h0, pulse_out}, 32'h1);
    wr(6'h1C, 32'h4);
    tick(2);
    chk({31'h0, pulse_out}, 32'h0);
    $display("one shot done");
  endtask
  task automatic t_hold;
    wr(6'h20, 32'h0);
    wr(6'h1C, 32'h1D);
    tick(30);
    chk({31'h0, pulse_out}, 32'h1);
    wr(6'h1C, 32'h0D);
    tick(30);
    chk({31'h0, pulse_out}, 32'h0);
    wr(6'h1C, 32'h4);
    $display("hold done");
  endtask
  task automatic t_bias;
    wr(6'h08, 32'd200000);
    rd(6'h08);
    chk(d, 32'h0001869F);
    // +999 units of bias fire a target 900 units ahead at once
    tick(20);
    rd(6'h0C);
    wr(6'h20, d + 32'd900);
    e = 32'(part_u.pulses);
    wr(6'h1C, 32'h5);
    tick(30);
    chk(32'(part_u.pulses), e + 32'h1);
    wr(6'h08, 32'hFFFCF2C0);
    rd(6'h08);
    chk(d, 32'hFFFE7961);
    wr(6'h08, 32'h0);
    $display("bias done");
  endtask
  task automatic t_repeat;
    rd(6'h0C);
    wr(6'h20, d + 32'd20);
    wr(6'h24, 32'h0);
    wr(6'h2C, 32'h2);
    wr(6'h28, 32'h2);
    wr(6'h1C, 32'h7);
    e = 32'(part_u.pulses);
    tick(100);
    chk(32'(part_u.pulses), e + 32'h1);
    tick(39800);
    chk(32'(part_u.pulses), e + 32'h1);
    tick(400);
    chk(32'(part_u.pulses), e + 32'h2);
    wr(6'h1C, 32'h4);
    $display("repeat done");
  endtask
  initial begin
    tick(20);
    reset_n <= 1'b1;
    t_reset;
    t_events;
    t_pulse;
    t_hold;
    t_bias;
    t_repeat;
    end_of_test;
  end
endmodule // test_etpu_top
